// *** design/link_training_defines.svh ***
`ifndef LINK_TRAINING_DEFINES_SVH
`define LINK_TRAINING_DEFINES_SVH
// Function
// - Lane 0 lowest field, lane 3 top field
// - Port exists only when build option on; here the port is always present and held inert when the option is off
// - Processor mode bypasses built-in TX adaptation
// - Processor sets lane mode-enable bit for control
// - Tap select: 01 main, 10 post, 11 pre
// - Increment bit sends increment coefficient command
// - Decrement bit sends decrement coefficient command
// - Preset bit sends preset coefficient command
// - Initialize bit sends initialize coefficient command
// - Timer-start bit starts lane error timer
// - Processor reports lane training error
// - Processor reports lane frame lock error
// - Processor reports lane receiver trained
// - Ready bit shows lane accepts commands
// - Frame-lock bit shows training frame lock
// - Handshake-complete bit after coefficient handshake
// - Timer-done bit at maximum timer count
// - Per-lane error count field, counter width
// - Rollover bit when error counter wraps
// - Limit bit when partner coefficients at extreme

`define LANES 4
`define TAP_W 2
`define CMD_W 3
`define BCW 4
`define TIMER_W 16

`define TAP_MAIN 2'h1
`define TAP_POST 2'h2
`define TAP_PRE 2'h3

`define CLK_PERIOD_NS 40
`define BER_TIME_NS 2000
`define BER_TIMER_CYCLES ((`BER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL 12'h000
`define REG_TAP 12'h004
`define REG_CMD 12'h008
`define REG_REPORT 12'h00C
`define REG_STATUS 12'h010
`define REG_COUNT 12'h014

`define CMD_INC_LSB 0
`define CMD_DEC_LSB 4
`define CMD_PRESET_LSB 8
`define CMD_INIT_LSB 12
`define CMD_TIMER_LSB 16

`define RPT_TRAIN_ERR_LSB 0
`define RPT_LOCK_ERR_LSB 4
`define RPT_RX_TRAINED_LSB 8

`define ST_READY_LSB 0
`define ST_LOCK_LSB 4
`define ST_DONE_LSB 8
`define ST_TIMER_LSB 12
`define ST_ROLL_LSB 16
`define ST_LIMIT_LSB 20
`endif

// *** design/link_training_pkg.sv ***
package link_training_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } lane_state_e;

  typedef enum logic [2:0] {
    CMD_HOLD = 3'h0,
    CMD_INC = 3'h1,
    CMD_DEC = 3'h2,
    CMD_PRESET = 3'h3,
    CMD_INIT = 3'h4
  } coef_cmd_e;
endpackage : link_training_pkg

// *** design/link_training_if.sv ***
`timescale 1ns/1ps
`include "link_training_defines.svh"
interface link_training_if;
  logic [3:0] mode_en;
  logic [7:0] tap_sel;
  logic [3:0] inc;
  logic [3:0] dec;
  logic [3:0] preset;
  logic [3:0] init;
  logic [3:0] lane_error_timer_start;
  logic [3:0] train_err;
  logic [3:0] lock_err;
  logic [3:0] rx_trained;
  logic [3:0] cmd_ready;
  logic [3:0] frame_lock;
  logic [3:0] lane_handshake_complete;
  logic [3:0] ber_timer_done;
  logic [4*`BCW-1:0] ber_count;
  logic [3:0] ber_rollover;
  logic [3:0] coef_limit;

  modport device (
    input mode_en, tap_sel, inc, dec, preset, init, lane_error_timer_start,
    input train_err, lock_err, rx_trained,
    output cmd_ready, frame_lock, lane_handshake_complete, ber_timer_done,
    output ber_count, ber_rollover, coef_limit
  );
  modport processor (
    output mode_en, tap_sel, inc, dec, preset, init, lane_error_timer_start,
    output train_err, lock_err, rx_trained,
    input cmd_ready, frame_lock, lane_handshake_complete, ber_timer_done,
    input ber_count, ber_rollover, coef_limit
  );
endinterface : link_training_if

// *** design/error_tally.sv ***
`timescale 1ns/1ps
`include "link_training_defines.svh"
module error_tally (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic count_en,
  output logic [`BCW-1:0] count,
  output logic rollover
);
  wire at_max = &count;

  // A clear in the same cycle as an error wins: the error belongs to the old window.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      rollover <= 1'b0;
    end else if (clear) begin
      count <= '0;
      rollover <= 1'b0;
    end else if (count_en) begin
      count <= count + `BCW'(1);
      if (at_max) begin
        rollover <= 1'b1;
      end
    end
  end
endmodule : error_tally

// *** design/link_training_device.sv ***
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "link_training_defines.svh"
module link_training_device #(
  parameter bit UP_ENABLE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  link_training_if.device lt,
  input wire logic [3:0] builtin_cmd_valid,
  input wire logic [4*`CMD_W-1:0] builtin_cmd,
  input wire logic [4*`TAP_W-1:0] builtin_tap,
  input wire logic [3:0] partner_ack,
  input wire logic [3:0] partner_at_limit,
  input wire logic [3:0] rx_frame_seen,
  input wire logic [3:0] bit_error,
  output logic [3:0] coef_cmd_valid,
  output logic [4*`CMD_W-1:0] coef_cmd,
  output logic [4*`TAP_W-1:0] coef_tap,
  output logic [3:0] lane_trained,
  output logic [3:0] lane_fault
);
  localparam logic [`TIMER_W-1:0] TIMER_LAST = `TIMER_W'(`BER_TIMER_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Command edges. Inputs are levels; only a rising edge is a request, so a
  // held bit issues at most one command.
  logic [3:0] inc_q;
  logic [3:0] dec_q;
  logic [3:0] preset_q;
  logic [3:0] init_q;
  logic [3:0] start_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inc_q <= '0;
      dec_q <= '0;
      preset_q <= '0;
      init_q <= '0;
      start_q <= '0;
    end else begin
      inc_q <= lt.inc;
      dec_q <= lt.dec;
      preset_q <= lt.preset;
      init_q <= lt.init;
      start_q <= lt.lane_error_timer_start;
    end
  end

  wire [3:0] inc_edge = lt.inc & ~inc_q;
  wire [3:0] dec_edge = lt.dec & ~dec_q;
  wire [3:0] preset_edge = lt.preset & ~preset_q;
  wire [3:0] init_edge = lt.init & ~init_q;
  wire [3:0] start_edge = lt.lane_error_timer_start & ~start_q;
  // Without the build option the processor port is inert and reads as zero.
  wire [3:0] proc_mode = lt.mode_en & {4{UP_ENABLE}};

  logic [3:0] ready_r;
  logic [3:0] lock_r;
  logic [3:0] done_r;
  logic [3:0] timer_done_r;
  logic [3:0] limit_r;
  logic [3:0] running;
  logic [3:0] tally_roll;
  logic [4*`BCW-1:0] tally_count;

  // Each lane runs its own handshake, error timer and tally; lanes never share state.
  genvar i;
  generate
    for (i = 0; i < `LANES; i++) begin : g_lane
      link_training_pkg::lane_state_e state;
      link_training_pkg::lane_state_e next_state;
      link_training_pkg::coef_cmd_e proc_cmd;
      logic [`CMD_W-1:0] cmd_r;
      logic [`TAP_W-1:0] tap_r;
      logic [`TIMER_W-1:0] timer;
      wire [`TAP_W-1:0] proc_tap = lt.tap_sel[i*`TAP_W +: `TAP_W];
      wire [`TAP_W-1:0] auto_tap = builtin_tap[i*`TAP_W +: `TAP_W];
      wire [`CMD_W-1:0] auto_cmd = builtin_cmd[i*`CMD_W +: `CMD_W];
      // A tap select of 00 names no tap, so the command is not taken.
      wire proc_valid = proc_mode[i] && (proc_cmd != link_training_pkg::CMD_HOLD) &&
                        (proc_tap != 2'h0);
      wire req_valid = proc_mode[i] ? proc_valid : builtin_cmd_valid[i];
      wire [`CMD_W-1:0] req_cmd = proc_mode[i] ? proc_cmd : auto_cmd;
      wire [`TAP_W-1:0] req_tap = proc_mode[i] ? proc_tap : auto_tap;
      wire timer_end = running[i] && (timer == TIMER_LAST);

      // Initialize outranks preset, then increment, then decrement.
      always_comb begin
        if (init_edge[i]) begin
          proc_cmd = link_training_pkg::CMD_INIT;
        end else if (preset_edge[i]) begin
          proc_cmd = link_training_pkg::CMD_PRESET;
        end else if (inc_edge[i]) begin
          proc_cmd = link_training_pkg::CMD_INC;
        end else if (dec_edge[i]) begin
          proc_cmd = link_training_pkg::CMD_DEC;
        end else begin
          proc_cmd = link_training_pkg::CMD_HOLD;
        end
      end

      // Requests that arrive outside idle are dropped; ready is low then.
      always_comb begin
        case (state)
          link_training_pkg::ST_IDLE: begin
            next_state = req_valid ? link_training_pkg::ST_SEND : link_training_pkg::ST_IDLE;
          end
          link_training_pkg::ST_SEND: begin
            next_state = link_training_pkg::ST_WAIT;
          end
          link_training_pkg::ST_WAIT: begin
            next_state = partner_ack[i] ? link_training_pkg::ST_DONE :
                         link_training_pkg::ST_WAIT;
          end
          link_training_pkg::ST_DONE: begin
            next_state = link_training_pkg::ST_IDLE;
          end
          default: begin
            next_state = link_training_pkg::ST_IDLE;
          end
        endcase
      end

      // Ready follows next_state, so it drops at the very edge that takes a request.
      // A processor that polls ready therefore cannot slip a second command in behind.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          state <= link_training_pkg::ST_IDLE;
          cmd_r <= '0;
          tap_r <= '0;
          coef_cmd_valid[i] <= 1'b0;
          ready_r[i] <= 1'b0;
          done_r[i] <= 1'b0;
        end else begin
          state <= next_state;
          coef_cmd_valid[i] <= (next_state == link_training_pkg::ST_SEND);
          ready_r[i] <= proc_mode[i] && (next_state == link_training_pkg::ST_IDLE);
          if (state == link_training_pkg::ST_IDLE && req_valid) begin
            cmd_r <= req_cmd;
            tap_r <= req_tap;
            done_r[i] <= 1'b0;
          end else if (next_state == link_training_pkg::ST_DONE) begin
            done_r[i] <= proc_mode[i];
          end
        end
      end

      // In processor mode a start pulse always restarts the window and clears the done flag and the tally.
      // A result left over from an earlier window is thus never read as the new one.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          timer <= '0;
          running[i] <= 1'b0;
          timer_done_r[i] <= 1'b0;
        end else if (proc_mode[i] && start_edge[i]) begin
          timer <= '0;
          running[i] <= 1'b1;
          timer_done_r[i] <= 1'b0;
        end else if (timer_end) begin
          running[i] <= 1'b0;
          timer_done_r[i] <= 1'b1;
        end else if (running[i]) begin
          timer <= timer + `TIMER_W'(1);
        end
      end

      // Errors count only while the timer runs, so a stray error between windows is lost.
      // The tally wraps rather than saturates; the rollover flag tells software it did.
      error_tally error_tally_i (
        .clk(clk),
        .rst_b(rst_b),
        .clear((proc_mode[i] && start_edge[i]) || !UP_ENABLE),
        .count_en(running[i] && bit_error[i]),
        .count(tally_count[i*`BCW +: `BCW]),
        .rollover(tally_roll[i])
      );

      assign coef_cmd[i*`CMD_W +: `CMD_W] = cmd_r;
      assign coef_tap[i*`TAP_W +: `TAP_W] = tap_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Lane status. Lock follows rx_frame_seen even while the processor flags a lock
  // error; that error reaches the user side only through lane_fault.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= '0;
      limit_r <= '0;
      lane_trained <= '0;
      lane_fault <= '0;
    end else begin
      lock_r <= rx_frame_seen & {4{UP_ENABLE}};
      limit_r <= partner_at_limit & {4{UP_ENABLE}};
      lane_trained <= proc_mode & lt.rx_trained & ~lt.train_err;
      lane_fault <= proc_mode & (lt.train_err | lt.lock_err);
    end
  end

  // Status leaves through the interface straight from the flops above.
  assign lt.cmd_ready = ready_r;
  assign lt.frame_lock = lock_r;
  assign lt.lane_handshake_complete = done_r;
  assign lt.ber_timer_done = timer_done_r;
  assign lt.ber_count = tally_count;
  assign lt.ber_rollover = tally_roll;
  assign lt.coef_limit = limit_r;
endmodule : link_training_device

// *** design/link_training_processor.sv ***
`timescale 1ns/1ps
`include "link_training_defines.svh"
module link_training_processor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  link_training_if.processor lt
);
  logic [3:0] mode_r;
  logic [7:0] tap_r;
  logic [19:0] cmd_pulse;
  logic [11:0] report_r;

  wire access = psel && penable && !pready;
  wire commit = psel && penable && pready;
  wire wr = commit && pwrite;
  wire hit_ctrl = (paddr == `REG_CTRL);
  wire hit_tap = (paddr == `REG_TAP);
  wire hit_cmd = (paddr == `REG_CMD);
  wire hit_report = (paddr == `REG_REPORT);
  wire hit_status = (paddr == `REG_STATUS);
  wire hit_count = (paddr == `REG_COUNT);
  wire mapped = hit_ctrl | hit_tap | hit_cmd | hit_report | hit_status | hit_count;
  // A lane under processor control that is busy must see no new coefficient command or tap change; timer starts still reach it.
  wire [3:0] lane_open = lt.cmd_ready | ~mode_r;
  wire [3:0] cmd_gate = lt.cmd_ready & mode_r;
  wire [31:0] status_word = {8'h00, lt.coef_limit, lt.ber_rollover, lt.ber_timer_done,
                             lt.lane_handshake_complete, lt.frame_lock, lt.cmd_ready};
  wire [31:0] read_word = hit_ctrl ? {28'h0000000, mode_r} :
                          hit_tap ? {24'h000000, tap_r} :
                          hit_report ? {20'h00000, report_r} :
                          hit_status ? status_word :
                          hit_count ? {16'h0000, lt.ber_count} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // One wait state: the answer is registered so prdata comes from a flop.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? read_word : 32'h00000000;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `LANES; i++) begin : g_tap
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tap_r[i*`TAP_W +: `TAP_W] <= `TAP_MAIN;
        end else if (wr && hit_tap && lane_open[i]) begin
          tap_r[i*`TAP_W +: `TAP_W] <= pwdata[i*`TAP_W +: `TAP_W];
        end
      end
    end
  endgenerate

  // Command bits last one cycle, giving the device a clean rising edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= '0;
      report_r <= '0;
      cmd_pulse <= '0;
    end else begin
      cmd_pulse <= '0;
      if (wr && hit_ctrl) begin
        mode_r <= pwdata[3:0];
      end
      if (wr && hit_report) begin
        report_r <= pwdata[11:0];
      end
      if (wr && hit_cmd) begin
        cmd_pulse <= pwdata[19:0] & {mode_r, {4{cmd_gate}}};
      end
    end
  end

  assign lt.mode_en = mode_r;
  assign lt.tap_sel = tap_r;
  assign lt.inc = cmd_pulse[`CMD_INC_LSB +: 4];
  assign lt.dec = cmd_pulse[`CMD_DEC_LSB +: 4];
  assign lt.preset = cmd_pulse[`CMD_PRESET_LSB +: 4];
  assign lt.init = cmd_pulse[`CMD_INIT_LSB +: 4];
  assign lt.lane_error_timer_start = cmd_pulse[`CMD_TIMER_LSB +: 4];
  assign lt.train_err = report_r[`RPT_TRAIN_ERR_LSB +: 4];
  assign lt.lock_err = report_r[`RPT_LOCK_ERR_LSB +: 4];
  assign lt.rx_trained = report_r[`RPT_RX_TRAINED_LSB +: 4];
endmodule : link_training_processor

// *** verif/link_training_checker.sv ***
`timescale 1ns/1ps
`include "link_training_defines.svh"
module link_training_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] mode_en,
  input wire logic [7:0] tap_sel,
  input wire logic [3:0] inc,
  input wire logic [3:0] dec,
  input wire logic [3:0] preset,
  input wire logic [3:0] init,
  input wire logic [3:0] lane_error_timer_start,
  input wire logic [3:0] cmd_ready,
  input wire logic [3:0] lane_handshake_complete,
  input wire logic [3:0] ber_timer_done,
  input wire logic [4*`BCW-1:0] ber_count,
  input wire logic [3:0] ber_rollover
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] cmds;
  logic [3:0] taken;
  logic [3:0] tap_set;
  assign cmds = inc | dec | preset | init;
  // A command with tap field 00 is ignored, so it must not count as taken.
  assign tap_set = {|tap_sel[7:6], |tap_sel[5:4], |tap_sel[3:2], |tap_sel[1:0]};
  assign taken = cmds & cmd_ready & tap_set;
  ////////////////////////////////////////////////////////////////////////////////////////////
  sequence s_cleared;
    !ber_timer_done[0] && ber_count[3:0] == 4'h0 && !ber_rollover[0];
  endsequence
  sequence s_timer_end;
    !ber_timer_done[0] ##1 ber_timer_done[0];
  endsequence
  property p_ready_mode;
    (cmd_ready & ~$past(mode_en)) == 4'h0;
  endproperty
  a_ready_mode: assert property (p_ready_mode) else $error("ready without mode");
  property p_cmd_pulse;
    (cmds & $past(cmds)) == 4'h0;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command not a pulse");
  property p_cmd_gate;
    (cmds & ~$past(cmd_ready)) == 4'h0;
  endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("command while not ready");
  property p_busy;
    taken[0] |=> !cmd_ready[0] [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("ready during handshake");
  property p_hs_clear;
    |taken |=> (lane_handshake_complete & $past(taken)) == 4'h0;
  endproperty
  a_hs_clear: assert property (p_hs_clear) else $error("stale handshake flag");
  property p_timer;
    lane_error_timer_start[0] && mode_en[0] |=> s_cleared ##49 s_timer_end;
  endproperty
  a_timer: assert property (p_timer) else $error("timer length wrong");
  property p_wrap;
    $past(ber_count[3:0]) == 4'hF && ber_count[3:0] == 4'h0
      && !$past(lane_error_timer_start[0]) |-> ber_rollover[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without rollover");
  property p_tap_hold;
    $changed(tap_sel[1:0]) && $past(mode_en[0]) |-> $past(cmd_ready[0]);
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("tap moved while busy");
endmodule : link_training_checker

// *** verif/test_link_training_processor_port.sv ***
`timescale 1ns/1ps
`include "link_training_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_link_training_processor_port;
  logic clk;
  logic rst_b;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] builtin_cmd_valid;
  logic [11:0] builtin_cmd;
  logic [7:0] builtin_tap;
  logic [3:0] partner_ack;
  logic [3:0] partner_at_limit;
  logic [3:0] rx_frame_seen;
  logic [3:0] bit_error;
  logic [3:0] coef_cmd_valid;
  logic [11:0] coef_cmd;
  logic [7:0] coef_tap;
  logic [3:0] lane_trained;
  logic [3:0] lane_fault;
  int err_count = 0;
  int total_checks = 0;
  integer seed;
  logic [64:0] rd_q[$];
  logic [6:0] cmd_q[$];
  logic [64:0] e;
  logic [6:0] c;
  logic [1:0] l;
  logic [1:0] t;
  logic [1:0] r;
  logic [7:0] tv;
  logic [31:0] v;
  int n;
  link_training_if lt_if();
  link_training_device link_training_device_i (.clk(clk), .rst_b(rst_b), .lt(lt_if),
    .builtin_cmd_valid(builtin_cmd_valid), .builtin_cmd(builtin_cmd),
    .builtin_tap(builtin_tap), .partner_ack(partner_ack), .partner_at_limit(partner_at_limit),
    .rx_frame_seen(rx_frame_seen), .bit_error(bit_error), .coef_cmd_valid(coef_cmd_valid),
    .coef_cmd(coef_cmd), .coef_tap(coef_tap), .lane_trained(lane_trained),
    .lane_fault(lane_fault));
  link_training_processor link_training_processor_i (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lt(lt_if));
  link_training_checker link_training_checker_i (.clk(clk), .rst_b(rst_b),
    .mode_en(lt_if.mode_en), .tap_sel(lt_if.tap_sel), .inc(lt_if.inc), .dec(lt_if.dec),
    .preset(lt_if.preset), .init(lt_if.init),
    .lane_error_timer_start(lt_if.lane_error_timer_start), .cmd_ready(lt_if.cmd_ready),
    .lane_handshake_complete(lt_if.lane_handshake_complete),
    .ber_timer_done(lt_if.ber_timer_done), .ber_count(lt_if.ber_count),
    .ber_rollover(lt_if.ber_rollover));
  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Each transfer starts one edge after the last, so psel is never assigned twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!pready && k < 50);
    if (!pready) begin
      err_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] d,
                    input logic err);
    rd_q.push_back({err, m, d});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  ////////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      e = rd_q.pop_front();
      `CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
    end
    for (int i = 0; i < 4; i++) begin
      if (coef_cmd_valid[i]) begin
        c = (cmd_q.size() > 0) ? cmd_q.pop_front() : 7'h7F;
        `CHK({2'(i), coef_cmd[3*i+:3], coef_tap[2*i+:2]}, c)
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  initial begin
    seed = 32'h7f4316bb;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {builtin_cmd_valid, builtin_cmd, builtin_tap, partner_ack} = '0;
    {partner_at_limit, rx_frame_seen, bit_error} = '0;
    rst_b = 1'b0;
    tv = 8'h55;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(`REG_TAP, 32'hFF, 32'h55, 1'b0);
    rd(`REG_STATUS, 32'hFFFFFFFF, 32'h0, 1'b0);
    rd(12'h020, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, `REG_CTRL, 32'hF);
    rd(`REG_STATUS, 32'hF, 32'hF, 1'b0);
    r = 2'($random(seed));
    // Kinds in CMD sit four bits apart, and their codes run 1 to 4 in the same order.
    for (int k = 0; k < 4; k++) begin
      l = 2'(k) + r;
      t = 2'(k % 3 + 1);
      tv[2*l+:2] = t;
      apb(1'b1, `REG_TAP, {24'h0, tv});
      cmd_q.push_back({l, 3'(k + 1), t});
      apb(1'b1, `REG_CMD, 32'h1 << (4 * k + l));
      apb(1'b1, `REG_CMD, 32'h1 << l);
      rd(`REG_STATUS, 32'h101 << l, 32'h0, 1'b0);
      cyc($unsigned($random(seed)) % 4);
      partner_ack[l] <= 1'b1;
      @(posedge clk);
      partner_ack[l] <= 1'b0;
      cyc(3);
      rd(`REG_STATUS, 32'h101 << l, 32'h101 << l, 1'b0);
    end
    apb(1'b1, `REG_CMD, 32'h1 << `CMD_TIMER_LSB);
    cyc(2);
    n = 16 + ($unsigned($random(seed)) % 4);
    repeat (n) begin
      bit_error[0] <= 1'b1;
      @(posedge clk);
      bit_error[0] <= 1'b0;
      @(posedge clk);
    end
    cyc(30);
    rd(`REG_STATUS, 32'h11000, 32'h11000, 1'b0);
    rd(`REG_COUNT, 32'hF, 32'(n - 16), 1'b0);
    v = $random(seed);
    rx_frame_seen <= v[3:0];
    partner_at_limit <= v[7:4];
    apb(1'b1, `REG_REPORT, {20'h0, 4'hF, v[11:8], v[15:12]});
    cyc(3);
    rd(`REG_STATUS, 32'hF000F0, {8'h0, v[7:4], 12'h0, v[3:0], 4'h0}, 1'b0);
    `CHK(lane_trained, ~v[15:12])
    `CHK(lane_fault, v[15:12] | v[11:8])
    apb(1'b1, `REG_CTRL, 32'h0);
    cyc(2);
    builtin_tap <= 8'hE4;
    builtin_cmd <= {3'h4, 3'h3, 3'h2, 3'h1};
    for (int k = 0; k < 4; k++) cmd_q.push_back({2'(k), 3'(k + 1), 2'(k)});
    builtin_cmd_valid <= 4'hF;
    @(posedge clk);
    builtin_cmd_valid <= 4'h0;
    cyc(4);
    partner_ack <= 4'hF;
    @(posedge clk);
    partner_ack <= 4'h0;
    cyc(4);
    `CHK(cmd_q.size() + rd_q.size(), 0)
    end_of_test();
  end
endmodule : test_link_training_processor_port
